/* File: adc_seq_map.vh */
// Purpose: register offsets, field positions and cycle counts of the converter sequencer
// Assumes: 32-bit apb data, one aligned word per register
// Notes: result word i sits at RESULT_BASE + 4*i
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STAT 8'h08
`define OFS_INT_MASK 8'h0C
`define OFS_RESULT_BASE 8'h20
`define OFS_RESULT_LAST 8'h3C

// control field positions
`define CTRL_START 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 3
`define CTRL_PIN_LO 4
`define CTRL_PIN_HI 6
`define CTRL_SWEEP_LO 7
`define CTRL_SWEEP_HI 8
`define CTRL_RES10 9
`define CTRL_TRIG_EXT 10
`define CTRL_GROUP_LO 11
`define CTRL_GROUP_HI 12
`define CTRL_DIV_LO 13
`define CTRL_DIV_HI 14
`define CTRL_RESET 32'h00000000

// operating modes
`define MODE_ONE_SHOT 3'h0
`define MODE_REPEAT 3'h1
`define MODE_SINGLE_SWEEP 3'h2
`define MODE_REP_SWEEP0 3'h3
`define MODE_REP_SWEEP1 3'h4

// interrupt status bit
`define INT_CONV_DONE 0

// converter clock cycles per input, no sample and hold
`define CONV_CYC_8BIT 6'h31
`define CONV_CYC_10BIT 6'h3B

`endif

/* File: adc_mode_sequencer.v */
// Purpose: mode sequencer for a successive-approximation converter with apb registers
// Assumes: conversion core samples the selected input while sampling is high
// Notes: one clock; converter clock is an enable pulse from a divider
//
// Notes on behaviour
// - one-shot converts selected input once per start, or once per trigger fall when triggered
// - one-shot/single sweep self-clear start unless triggered
// - writing start 0 stops any mode
// - completion interrupt in one-shot, single sweep only
// - repeat mode reconverts selected input, no interrupt
// - single sweep covers inputs 0-1/0-3/0-5/0-7 once
// - repeat sweep 0 loops the group, no interrupt
// - repeat sweep 1 interleaves emphasised inputs
// - emphasised set is 0, 0-1, 0-2 or 0-3
// - each result lands in its input's register
// - extended groups behave like primary inputs
// - 10-bit: low byte even, two bits odd
// - 49 cycles at 8 bits, 59 at 10
// - falling external trigger (re)starts while start set
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_seq_map.vh"

module adc_mode_sequencer #(
  parameter NUM_INPUTS = 8,
  parameter RES_BITS = 10
)
(
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_conversion_trigger,
  input wire [RES_BITS-1:0] convResult,
  output reg [2:0] anaChannel,
  output reg [1:0] anaGroup,
  output reg sampling,
  output reg irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  reg startQ;
  reg goQ;
  reg [2:0] modeQ;
  reg [2:0] pinSelQ;
  reg [1:0] sweepSelQ;
  reg res10Q;
  reg trigExtQ;
  reg [1:0] groupQ;
  reg [1:0] clkDivQ;
  reg intStatQ;
  reg intMaskQ;
  reg [2:0] stateQ;
  reg [2:0] chanQ;
  reg [1:0] emphQ;
  reg [2:0] otherQ;
  reg emphPhaseQ;
  reg [5:0] cycCntQ;
  reg [1:0] divCntQ;
  reg phiEnQ;
  reg trigPrevQ;

  // bus decode
  wire accessQ = psel & penable & pready;
  wire wrAcc = accessQ & pwrite;
  wire wrCtrl = wrAcc & (paddr == `OFS_CTRL);
  wire wrStop = wrCtrl & ~pwdata[`CTRL_START];
  wire wrStart = wrCtrl & pwdata[`CTRL_START] & ~startQ;

  // converter clock enable: divide by 1, 2 or 4
  wire [1:0] divMax = (clkDivQ == 2'h0) ? 2'h0 : ((clkDivQ == 2'h1) ? 2'h1 : 2'h3);
  wire [5:0] needCyc = res10Q ? `CONV_CYC_10BIT : `CONV_CYC_8BIT;

  wire trigFall = trigPrevQ & ~external_conversion_trigger;
  wire retrig = trigExtQ & startQ & trigFall & stateQ[2];
  wire convEnd = stateQ[2] & phiEnQ & (cycCntQ == needCyc - 6'h01) & ~wrStop & ~retrig;

  wire [2:0] lastChan = {sweepSelQ, 1'b1};
  wire [2:0] emphCount = {1'b0, sweepSelQ} + 3'h1;
  wire oneShotType = (modeQ == `MODE_ONE_SHOT) | (modeQ == `MODE_SINGLE_SWEEP);
  wire [2:0] firstChan = ((modeQ == `MODE_ONE_SHOT) | (modeQ == `MODE_REPEAT)) ?
    pinSelQ : 3'h0;

  // next input after a finished conversion
  reg [2:0] nextChan;
  reg [1:0] nextEmph;
  reg [2:0] nextOther;
  reg nextPhase;
  reg seqDone;
  always @*
  begin
    nextChan = chanQ;
    nextEmph = emphQ;
    nextOther = otherQ;
    nextPhase = emphPhaseQ;
    seqDone = 1'b0;
    case (modeQ)
      `MODE_ONE_SHOT:
      begin
        seqDone = 1'b1;
      end
      `MODE_REPEAT:
      begin
        nextChan = chanQ;
      end
      `MODE_SINGLE_SWEEP:
      begin
        if (chanQ == lastChan)
          seqDone = 1'b1;
        else
          nextChan = chanQ + 3'h1;
      end
      `MODE_REP_SWEEP0:
      begin
        nextChan = (chanQ == lastChan) ? 3'h0 : chanQ + 3'h1;
      end
      `MODE_REP_SWEEP1:
      begin
        // emphasised block first, then one of the remaining inputs
        if (!emphPhaseQ)
        begin
          if (emphQ == sweepSelQ)
          begin
            nextPhase = 1'b1;
            nextChan = otherQ;
          end
          else
          begin
            nextEmph = emphQ + 2'h1;
            nextChan = {1'b0, emphQ + 2'h1};
          end
        end
        else
        begin
          nextOther = (otherQ == 3'h7) ? emphCount : otherQ + 3'h1;
          nextPhase = 1'b0;
          nextEmph = 2'h0;
          nextChan = 3'h0;
        end
      end
      default:
      begin
        seqDone = 1'b1;
      end
    endcase
  end

  // converter clock divider
  always @(posedge clk)
  begin
    if (rst)
    begin
      divCntQ <= 2'h0;
      phiEnQ <= 1'b0;
      trigPrevQ <= 1'b1;
    end
    else
    begin
      trigPrevQ <= external_conversion_trigger;
      if (divCntQ >= divMax)
      begin
        divCntQ <= 2'h0;
        phiEnQ <= 1'b1;
      end
      else
      begin
        divCntQ <= divCntQ + 2'h1;
        phiEnQ <= 1'b0;
      end
    end
  end

  // control register and sequencer
  always @(posedge clk)
  begin
    if (rst)
    begin
      startQ <= 1'b0;
      goQ <= 1'b0;
      modeQ <= `MODE_ONE_SHOT;
      pinSelQ <= 3'h0;
      sweepSelQ <= 2'h0;
      res10Q <= 1'b0;
      trigExtQ <= 1'b0;
      groupQ <= 2'h0;
      clkDivQ <= 2'h0;
      stateQ <= ST_IDLE;
      chanQ <= 3'h0;
      emphQ <= 2'h0;
      otherQ <= 3'h1;
      emphPhaseQ <= 1'b0;
      cycCntQ <= 6'h00;
      sampling <= 1'b0;
      anaChannel <= 3'h0;
      anaGroup <= 2'h0;
    end
    else
    begin
      goQ <= wrStart;
      if (wrCtrl)
      begin
        modeQ <= pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
        pinSelQ <= pwdata[`CTRL_PIN_HI:`CTRL_PIN_LO];
        sweepSelQ <= pwdata[`CTRL_SWEEP_HI:`CTRL_SWEEP_LO];
        res10Q <= pwdata[`CTRL_RES10];
        trigExtQ <= pwdata[`CTRL_TRIG_EXT];
        groupQ <= pwdata[`CTRL_GROUP_HI:`CTRL_GROUP_LO];
        clkDivQ <= pwdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
      end
      if (wrStop)
      begin
        // a stop write ends every mode at once
        startQ <= 1'b0;
        stateQ <= ST_IDLE;
        sampling <= 1'b0;
        goQ <= 1'b0;
      end
      else
      begin
        if (wrStart)
          startQ <= 1'b1;
        case (stateQ)
          ST_IDLE:
          begin
            // config settles one cycle before the first input is chosen
            if (goQ)
            begin
              chanQ <= firstChan;
              anaChannel <= firstChan;
              anaGroup <= groupQ;
              emphQ <= 2'h0;
              otherQ <= emphCount;
              emphPhaseQ <= 1'b0;
              cycCntQ <= 6'h00;
              stateQ <= trigExtQ ? ST_WAIT : ST_CONV;
              sampling <= ~trigExtQ;
            end
          end
          ST_WAIT:
          begin
            if (trigFall)
            begin
              stateQ <= ST_CONV;
              sampling <= 1'b1;
              cycCntQ <= 6'h00;
            end
          end
          ST_CONV:
          begin
            if (retrig)
            begin
              // retrigger restarts the sequence from its first input
              chanQ <= firstChan;
              anaChannel <= firstChan;
              emphQ <= 2'h0;
              otherQ <= emphCount;
              emphPhaseQ <= 1'b0;
              cycCntQ <= 6'h00;
            end
            else if (convEnd)
            begin
              cycCntQ <= 6'h00;
              if (seqDone)
              begin
                if (trigExtQ)
                begin
                  stateQ <= ST_WAIT;
                end
                else
                begin
                  startQ <= 1'b0;
                  stateQ <= ST_IDLE;
                end
                sampling <= 1'b0;
              end
              else
              begin
                chanQ <= nextChan;
                anaChannel <= nextChan;
                emphQ <= nextEmph;
                otherQ <= nextOther;
                emphPhaseQ <= nextPhase;
              end
            end
            else if (phiEnQ)
            begin
              cycCntQ <= cycCntQ + 6'h01;
            end
          end
          default:
          begin
            stateQ <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // result store, one word per input
  wire [NUM_INPUTS*16-1:0] resultFlat;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1)
    begin : resultSlot
      reg [15:0] valQ;
      always @(posedge clk)
      begin
        if (rst)
          valQ <= 16'h0000;
        else if (convEnd && (chanQ == gi))
        begin
          // low byte at even byte lane, two top bits at odd lane
          if (res10Q)
            valQ <= {6'h00, convResult};
          else
            valQ <= {8'h00, convResult[RES_BITS-1:RES_BITS-8]};
        end
      end
      assign resultFlat[gi*16 +: 16] = valQ;
    end
  endgenerate

  // interrupt status, set wins over a clearing write
  wire intEvent = convEnd & seqDone & oneShotType;
  wire wrIntClr = wrAcc & (paddr == `OFS_INT_STAT) & pwdata[`INT_CONV_DONE];
  always @(posedge clk)
  begin
    if (rst)
    begin
      intStatQ <= 1'b0;
      intMaskQ <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (intEvent)
        intStatQ <= 1'b1;
      else if (wrIntClr)
        intStatQ <= 1'b0;
      if (wrAcc && (paddr == `OFS_INT_MASK))
        intMaskQ <= pwdata[`INT_CONV_DONE];
      irq <= (intStatQ | intEvent) & intMaskQ;
    end
  end

  // apb: one wait state, read data registered with pready
  wire [2:0] resIdx = paddr[4:2];
  wire isResult = (paddr >= `OFS_RESULT_BASE) && (paddr <= `OFS_RESULT_LAST) &&
    (paddr[1:0] == 2'h0);
  always @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      if (psel && penable && !pready)
      begin
        if (paddr == `OFS_CTRL)
          prdata <= {17'h00000, clkDivQ, groupQ, trigExtQ, res10Q, sweepSelQ,
            pinSelQ, modeQ, startQ};
        else if (paddr == `OFS_STATUS)
          prdata <= {25'h0000000, anaGroup, anaChannel, sampling, startQ};
        else if (paddr == `OFS_INT_STAT)
          prdata <= {31'h00000000, intStatQ};
        else if (paddr == `OFS_INT_MASK)
          prdata <= {31'h00000000, intMaskQ};
        else if (isResult)
          prdata <= {16'h0000, resultFlat[resIdx*16 +: 16]};
        else
          pslverr <= 1'b1;
      end
    end
  end

endmodule

/* File: adc_core_model.sv */
// Purpose: stand-in for the analog mux and conversion core
// Assumes: result only meaningful while sampling is high
// Notes: code holds group and channel, so a misrouted result shows
`timescale 1ns/100ps
module adc_core_model (
  input wire clk,
  input wire sampling,
  input wire [2:0] anaChannel,
  input wire [1:0] anaGroup,
  output reg [9:0] convResult
);
  initial convResult = 10'h000;
  // toggles when idle so stale data cannot pass for a result
  always @(posedge clk)
    if (sampling)
      convResult <= {anaGroup, anaChannel, 5'h0A};
    else
      convResult <= ~convResult;
endmodule

/* File: adc_mode_sequencer_assertions.sv */
// Purpose: port checks for the converter sequencer
// Assumes: apb slave with one wait state
// Notes: start and stop windows allow one cycle of slack
`timescale 1ns/100ps
module adc_mode_sequencer_assertions (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] anaGroup,
  input wire sampling,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  sequence s_go;
    s_ctrl_wr ##0 (pwdata[0] && !pwdata[10] && !sampling);
  endsequence
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("idle bus not quiet");
  a_err_unmapped: assert property (pready && (paddr[1:0] != 2'h0 || paddr > 8'h3C
    || (paddr > 8'h0C && paddr < 8'h20)) |-> pslverr)
    else $error("unmapped access not refused");
  a_start_latency: assert property (s_go |-> ##[2:3] sampling)
    else $error("conversion did not start");
  a_stop_now: assert property (s_ctrl_wr ##0 !pwdata[0] |-> ##[1:2] !sampling)
    else $error("conversion did not stop");
  a_group_hold: assert property (sampling && $past(sampling) |-> $stable(anaGroup))
    else $error("group moved mid conversion");
  a_irq_at_end: assert property ($rose(irq) |-> !sampling)
    else $error("irq before conversion end");
endmodule
bind adc_mode_sequencer adc_mode_sequencer_assertions chk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .anaGroup(anaGroup),
  .sampling(sampling), .irq(irq));

/* File: tb_top.sv */
// Purpose: self-checking bench for the converter sequencer
// Assumes: apb master, core model on the analog side
// Notes: every run divides the converter clock by four, so it stays at 10 MHz
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h00000000;
  reg trig = 1'b1;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire sampling;
  wire irq;
  wire [9:0] convResult;
  wire [2:0] anaChannel;
  wire [1:0] anaGroup;
  reg [31:0] rd;
  reg er;
  reg prevS = 1'b0;
  reg [2:0] prevC = 3'h0;
  reg [2:0] seen[$];
  reg [7:0] i;
  integer errCount = 0;
  integer nChecks = 0;
  integer cyc = 0;
  integer k;
  always #12.5 clk = ~clk;
  adc_mode_sequencer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_conversion_trigger(trig), .convResult(convResult),
    .anaChannel(anaChannel), .anaGroup(anaGroup), .sampling(sampling), .irq(irq));
  adc_core_model core (.clk(clk), .sampling(sampling), .anaChannel(anaChannel),
    .anaGroup(anaGroup), .convResult(convResult));
  task finalReport;
    begin
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      nChecks = nChecks + 1;
      if (s !== e)
      begin
        errCount = errCount + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task apb(input [7:0] a, input [31:0] d, input w);
    begin
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwdata <= d;
      pwrite <= w;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // log each new input taken up; a hang ends the run here
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prevS <= sampling;
    prevC <= anaChannel;
    if (sampling === 1'b1 && (prevS !== 1'b1 || anaChannel !== prevC))
      seen.push_back(anaChannel);
    if (cyc == 20000)
    begin
      errCount = errCount + 1;
      finalReport;
    end
  end
  task tRegs;
    begin
      apb(8'h00, 32'h0, 0);
      chk(rd, 32'h0);
      apb(8'h04, 32'h0, 0);
      chk(rd, 32'h0);
      apb(8'h10, 32'hFFFFFFFF, 1);
      chk(er, 1'b1);
      apb(8'h10, 32'h0, 0);
      chk(rd, 32'h0);
      apb(8'h0C, 32'h1, 1);
    end
  endtask
  task tOneShot;
    begin
      apb(8'h00, 32'h6031, 1);
      k = 0;
      do @(posedge clk); while (sampling !== 1'b1);
      chk(anaChannel, 3'h3);
      while (sampling === 1'b1)
      begin
        k = k + 1;
        @(posedge clk);
      end
      // divider phase adds up to three clocks, so count whole enables
      chk((k + 3) / 4, 32'h31);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      apb(8'h04, 32'h0, 0);
      chk(rd[0], 1'b0);
      apb(8'h2C, 32'h0, 0);
      chk(rd, 32'h1A);
      apb(8'h08, 32'h1, 1);
      apb(8'h08, 32'h0, 0);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
    end
  endtask
  task tTrigger;
    begin
      apb(8'h00, 32'h6421, 1);
      repeat (8) @(posedge clk);
      chk(sampling, 1'b0);
      trig <= 1'b0;
      do @(posedge clk); while (sampling !== 1'b1);
      chk(anaChannel, 3'h2);
      trig <= 1'b1;
      repeat (100) @(posedge clk);
      // a second fall mid-conversion restarts the full count
      trig <= 1'b0;
      k = 0;
      while (sampling === 1'b1)
      begin
        k = k + 1;
        @(posedge clk);
      end
      chk((k + 1) / 4, 32'h31);
      trig <= 1'b1;
      apb(8'h04, 32'h0, 0);
      chk(rd[0], 1'b1);
      apb(8'h28, 32'h0, 0);
      chk(rd, 32'h12);
      apb(8'h00, 32'h6420, 1);
      apb(8'h04, 32'h0, 0);
      chk(rd[0], 1'b0);
    end
  endtask
  task tRepeat;
    begin
      apb(8'h08, 32'h1, 1);
      apb(8'h00, 32'h6053, 1);
      // three conversions of 49 enables at a quarter rate
      repeat (600) @(posedge clk);
      apb(8'h04, 32'h0, 0);
      chk(rd[0], 1'b1);
      apb(8'h34, 32'h0, 0);
      chk(rd, 32'h2A);
      apb(8'h00, 32'h6052, 1);
      apb(8'h04, 32'h0, 0);
      chk(rd[1:0], 2'h0);
      apb(8'h08, 32'h0, 0);
      chk(rd, 32'h0);
    end
  endtask
  task tSeq(input [31:0] c, input integer n, input [31:0] e, input rep);
    begin
      apb(8'h08, 32'h1, 1);
      seen.delete();
      apb(8'h00, c, 1);
      while (seen.size() < n) @(posedge clk);
      chk(anaGroup, c[12:11]);
      for (i = 0; i < n; i = i + 1)
        chk(seen[i], e[4*i +: 3]);
      if (rep)
        apb(8'h00, c & 32'hFFFFFFFE, 1);
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(8'h04, 32'h0, 0);
      apb(8'h08, 32'h0, 0);
      chk(rd[0], !rep);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tRegs;
    tOneShot;
    tTrigger;
    tRepeat;
    tSeq(32'h6A85, 4, 32'h3210, 1'b0);
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(8'h20 + (i << 2), 32'h0, 0);
      chk(rd, 32'h10A + (i << 5));
    end
    tSeq(32'h7007, 5, 32'h01010, 1'b1);
    tSeq(32'h6009, 4, 32'h2010, 1'b1);
    tSeq(32'h6089, 6, 32'h00310210, 1'b1);
    finalReport;
  end
endmodule
